// [logic/flash_program_erase_control.v]
// Functional notes
// - programming acts on one 128-byte unit aligned at low byte 00 or 80
// - five erase blocks: four of 1 kbyte, one of 28 kbytes, one per erase
// - mode-control bit 7 is reserved and always reads zero
// - bit 6 gates writes; while 0 no other mode or select bit can be set
// - bit 5 enters erase-setup; clearing it leaves erase-setup
// - bit 4 enters program-setup; clearing it leaves program-setup
// - bit 3 enters erase-verify; clearing it leaves erase-verify
// - bit 2 enters program-verify; clearing it leaves program-verify
// - bit 1 enters erase only while gate and erase-setup are both one
// - bit 0 enters program only while gate and program-setup are one
// - status bit 7 flags a failed operation and enters error protection
// - select cleared while gate is zero, and on more than one bit set
// - select bits 4..0 pick 28k block at 1000, then 0C00,0800,0400,0000
// - control registers respond only while access-enable bit 7 is one
`timescale 1ns/100ps
`default_nettype none
`include "flash_ctrl_map.vh"

module flash_program_erase_control (
   // clock and reset
   input wire clk,
   input wire rst_b,
   // axi4-lite write address
   input wire s_axi_awvalid,
   output wire s_axi_awready,
   input wire [7:0] s_axi_awaddr,
   // axi4-lite write data
   input wire s_axi_wvalid,
   output wire s_axi_wready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   // axi4-lite write response
   output wire s_axi_bvalid,
   input wire s_axi_bready,
   output wire [1:0] s_axi_bresp,
   // axi4-lite read address
   input wire s_axi_arvalid,
   output wire s_axi_arready,
   input wire [7:0] s_axi_araddr,
   // axi4-lite read data
   output wire s_axi_rvalid,
   input wire s_axi_rready,
   output wire [31:0] s_axi_rdata,
   output wire [1:0] s_axi_rresp,
   // array status, asynchronous to clk
   input wire array_fail,
   input wire array_busy,
   // array mode controls
   output wire write_enable_gate,
   output wire erase_setup,
   output wire program_setup,
   output wire erase_verify,
   output wire program_verify,
   output wire erase_mode,
   output wire program_mode,
   output wire [4:0] erase_block_select,
   output wire [14:0] program_unit_addr,
   output wire flash_error_flag,
   // interrupt
   output wire irq
);

   reg [6:0] mode_q;
   reg [6:0] mode_d;
   reg [4:0] select_q;
   reg [4:0] select_d;
   reg access_q;
   reg err_q;
   reg [7:0] unit_q;
   reg [1:0] ist_q;
   reg [1:0] imsk_q;
   reg irq_q;
   reg fail_s1_q;
   reg fail_s2_q;
   reg busy_s1_q;
   reg busy_s2_q;
   reg busy_d1_q;

   reg aw_held_q;
   reg [7:0] aw_addr_q;
   reg w_held_q;
   reg [7:0] w_data_q;
   reg w_lane_q;
   reg bvalid_q;
   reg [1:0] bresp_q;
   reg rvalid_q;
   reg [31:0] rdata_q;
   reg [1:0] rresp_q;
   reg awready_q;
   reg wready_q;
   reg arready_q;

   wire do_write;
   wire wr_en;
   wire ctrl_ok;
   wire ev_fault;
   wire ev_done;
   wire [1:0] ev;
   wire [1:0] ist_clr;

   // true when the offset is a flash control register behind access-enable
   function is_ctrl;
      input [7:0] a;
      begin
         is_ctrl = (a == `OFS_MODE) || (a == `OFS_STATUS) ||
                   (a == `OFS_SELECT) || (a == `OFS_UNIT);
      end
   endfunction

   function is_mapped;
      input [7:0] a;
      begin
         is_mapped = is_ctrl(a) || (a == `OFS_ACCESS) ||
                     (a == `OFS_IRQ_STAT) || (a == `OFS_IRQ_MASK);
      end
   endfunction

   // more than one bit set in the select field
   function multi_bit;
      input [4:0] v;
      begin
         multi_bit = ((v & (v - 5'h01)) != 5'h00);
      end
   endfunction

   // only set bits are interlocked; clearing is always accepted
   function [6:0] mode_write;
      input [6:0] cur;
      input [7:0] wd;
      input err;
      reg gate;
      begin
         gate = cur[`MODE_GATE];
         mode_write = 7'h00;
         mode_write[`MODE_GATE] = wd[`MODE_GATE];
         mode_write[`MODE_ESU] = wd[`MODE_ESU] & gate;
         mode_write[`MODE_PSU] = wd[`MODE_PSU] & gate;
         mode_write[`MODE_EV] = wd[`MODE_EV] & gate;
         mode_write[`MODE_PV] = wd[`MODE_PV] & gate;
         mode_write[`MODE_ERASE] = wd[`MODE_ERASE] & gate &
                                   cur[`MODE_ESU] & ~err;
         mode_write[`MODE_PROG] = wd[`MODE_PROG] & gate &
                                  cur[`MODE_PSU] & ~err;
      end
   endfunction

   function [31:0] read_word;
      input [7:0] a;
      input ok;
      begin
         read_word = 32'h0000_0000;
         if (!ok && is_ctrl(a))
            read_word = 32'h0000_0000;
         else
            case (a)
               `OFS_MODE: read_word = {25'h0, mode_q};
               // error flag in status top bit
               `OFS_STATUS: read_word = {24'h000000, err_q, 7'h00};
               `OFS_SELECT: read_word = {27'h0, select_q};
               `OFS_ACCESS: read_word = {24'h0, access_q, 7'h00};
               `OFS_IRQ_STAT: read_word = {30'h0, ist_q};
               `OFS_IRQ_MASK: read_word = {30'h0, imsk_q};
               `OFS_UNIT: read_word = {17'h0, unit_q, 7'h00};
               default: read_word = 32'h0000_0000;
            endcase
      end
   endfunction

   // ready lines leave flops, so no bus output has a combinational path
   assign s_axi_awready = awready_q;
   assign s_axi_wready = wready_q;
   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp = bresp_q;
   assign s_axi_arready = arready_q;
   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rdata = rdata_q;
   assign s_axi_rresp = rresp_q;

   assign do_write = aw_held_q & w_held_q & ~bvalid_q;
   assign ctrl_ok = access_q;
   assign wr_en = do_write & w_lane_q &
                  (ctrl_ok | ~is_ctrl(aw_addr_q));

   // a failure only counts while erase or program mode is set
   assign ev_fault = fail_s2_q &
                     (mode_q[`MODE_ERASE] | mode_q[`MODE_PROG]);
   assign ev_done = busy_d1_q & ~busy_s2_q;
   assign ev = {ev_done, ev_fault};
   assign ist_clr = (wr_en && aw_addr_q == `OFS_IRQ_STAT) ?
                    w_data_q[1:0] : 2'h0;

   always @*
   begin
      mode_d = mode_q;
      select_d = select_q;
      if (wr_en && aw_addr_q == `OFS_MODE)
         mode_d = mode_write(mode_q, w_data_q, err_q);
      if (wr_en && aw_addr_q == `OFS_SELECT)
         select_d = w_data_q[4:0] & {5{mode_q[`MODE_GATE]}};
      // several blocks at once clears all
      if (multi_bit(select_d))
         select_d = `SELECT_RST;
      // gate low holds other bits clear
      if (!mode_q[`MODE_GATE])
      begin
         mode_d[5:0] = 6'h00;
         select_d = `SELECT_RST;
      end
      // error protection stops program and erase
      if (err_q || ev_fault)
      begin
         mode_d[`MODE_ERASE] = 1'b0;
         mode_d[`MODE_PROG] = 1'b0;
      end
   end

   always @(posedge clk)
   begin
      if (!rst_b)
      begin
         mode_q <= `MODE_RST;
         select_q <= `SELECT_RST;
         access_q <= 1'b0;
         err_q <= 1'b0;
         unit_q <= `UNIT_RST;
         ist_q <= `IRQ_RST;
         imsk_q <= `IRQ_RST;
         irq_q <= 1'b0;
         fail_s1_q <= 1'b0;
         fail_s2_q <= 1'b0;
         busy_s1_q <= 1'b0;
         busy_s2_q <= 1'b0;
         busy_d1_q <= 1'b0;
      end
      else
      begin
         fail_s1_q <= array_fail;
         fail_s2_q <= fail_s1_q;
         busy_s1_q <= array_busy;
         busy_s2_q <= busy_s1_q;
         busy_d1_q <= busy_s2_q;
         mode_q <= mode_d;
         // one block selected at a time
         select_q <= select_d;
         // sticky until reset, no software clear
         if (ev_fault)
            err_q <= 1'b1;
         if (wr_en && aw_addr_q == `OFS_ACCESS)
            access_q <= w_data_q[`ACCESS_EN];
         if (wr_en && aw_addr_q == `OFS_UNIT)
            unit_q <= w_data_q[7:0];
         if (wr_en && aw_addr_q == `OFS_IRQ_MASK)
            imsk_q <= w_data_q[1:0];
         // new events win over a clear in the same cycle
         ist_q <= (ist_q & ~ist_clr) | ev;
         irq_q <= |(((ist_q & ~ist_clr) | ev) & imsk_q);
      end
   end

   // bus slave: address and data taken in either order
   always @(posedge clk)
   begin
      if (!rst_b)
      begin
         aw_held_q <= 1'b0;
         aw_addr_q <= 8'h00;
         w_held_q <= 1'b0;
         w_data_q <= 8'h00;
         w_lane_q <= 1'b0;
         bvalid_q <= 1'b0;
         bresp_q <= `RESP_OKAY;
         rvalid_q <= 1'b0;
         rdata_q <= 32'h0000_0000;
         rresp_q <= `RESP_OKAY;
         awready_q <= 1'b1;
         wready_q <= 1'b1;
         arready_q <= 1'b1;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_held_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
            awready_q <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_held_q <= 1'b1;
            w_data_q <= s_axi_wdata[7:0];
            w_lane_q <= s_axi_wstrb[0];
            wready_q <= 1'b0;
         end
         if (do_write)
         begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            bvalid_q <= 1'b1;
            bresp_q <= is_mapped(aw_addr_q) ? `RESP_OKAY : `RESP_SLVERR;
         end
         else if (bvalid_q && s_axi_bready)
         begin
            bvalid_q <= 1'b0;
            awready_q <= 1'b1;
            wready_q <= 1'b1;
         end
         if (s_axi_arvalid && s_axi_arready)
         begin
            rvalid_q <= 1'b1;
            rdata_q <= read_word(s_axi_araddr, ctrl_ok);
            rresp_q <= is_mapped(s_axi_araddr) ? `RESP_OKAY :
                       `RESP_SLVERR;
            arready_q <= 1'b0;
         end
         else if (rvalid_q && s_axi_rready)
         begin
            rvalid_q <= 1'b0;
            arready_q <= 1'b1;
         end
      end
   end

   assign write_enable_gate = mode_q[`MODE_GATE];
   assign erase_setup = mode_q[`MODE_ESU];
   assign program_setup = mode_q[`MODE_PSU];
   assign erase_verify = mode_q[`MODE_EV];
   assign program_verify = mode_q[`MODE_PV];
   assign erase_mode = mode_q[`MODE_ERASE];
   assign program_mode = mode_q[`MODE_PROG];
   // select bit order toward block bases
   assign erase_block_select = select_q;
   assign program_unit_addr = {unit_q, 7'h00};
   assign flash_error_flag = err_q;
   assign irq = irq_q;

endmodule // flash_program_erase_control

`default_nettype wire

// [logic/flash_ctrl_map.vh]
`ifndef FLASH_CTRL_MAP_VH
`define FLASH_CTRL_MAP_VH

// register byte offsets
`define OFS_MODE 8'h00
`define OFS_STATUS 8'h04
`define OFS_SELECT 8'h08
`define OFS_ACCESS 8'h0C
`define OFS_IRQ_STAT 8'h10
`define OFS_IRQ_MASK 8'h14
`define OFS_UNIT 8'h18

// mode-control fields
`define MODE_GATE 6
`define MODE_ESU 5
`define MODE_PSU 4
`define MODE_EV 3
`define MODE_PV 2
`define MODE_ERASE 1
`define MODE_PROG 0
`define MODE_RST 7'h00

// status, access-enable and select fields
`define STATUS_ERR 7
`define ACCESS_EN 7
`define SELECT_RST 5'h00
`define SELECT_LARGE 4
`define SELECT_FIRST_SMALL 0

// erase block bases
`define BLK_LARGE_BASE 15'h1000
`define BLK_LARGE_TOP 15'h7FFF
`define BLK_SMALL3_BASE 15'h0C00
`define BLK_SMALL2_BASE 15'h0800
`define BLK_SMALL1_BASE 15'h0400
`define BLK_SMALL0_BASE 15'h0000

// programming unit: 128 bytes, address bits 14:7 kept
`define UNIT_LSB 7
`define UNIT_RST 8'h00

// interrupt events
`define IRQ_FAULT 0
`define IRQ_DONE 1
`define IRQ_RST 2'h0

// bus responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// [test/flash_program_erase_control_chk.sv]
`timescale 1ns/100ps
`default_nettype none
module flash_program_erase_control_chk (
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // mode outputs
   input wire logic write_enable_gate,
   input wire logic erase_setup,
   input wire logic program_setup,
   input wire logic erase_verify,
   input wire logic program_verify,
   input wire logic erase_mode,
   input wire logic program_mode,
   // block, unit and error
   input wire logic [4:0] erase_block_select,
   input wire logic [14:0] program_unit_addr,
   input wire logic flash_error_flag
);
   wire [5:0] gated = {erase_setup, program_setup, erase_verify,
      program_verify, erase_mode, program_mode};
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_b);
   property p_gate_off;
      !write_enable_gate |=> gated == 6'h00 && erase_block_select == 5'h00;
   endproperty
   a_gate_off: assert property (p_gate_off)
      else $error("bits set with gate off");
   property p_erase_in;
      $rose(erase_mode) |-> $past(write_enable_gate) && $past(erase_setup);
   endproperty
   a_erase_in: assert property (p_erase_in)
      else $error("erase entered without gate and setup");
   property p_prog_in;
      $rose(program_mode) |-> $past(write_enable_gate) && $past(program_setup);
   endproperty
   a_prog_in: assert property (p_prog_in)
      else $error("program entered without gate and setup");
   property p_one_block;
      $onehot0(erase_block_select);
   endproperty
   a_one_block: assert property (p_one_block)
      else $error("more than one erase block selected");
   property p_unit_align;
      program_unit_addr[6:0] == 7'h00;
   endproperty
   a_unit_align: assert property (p_unit_align)
      else $error("program unit not 128-byte aligned");
   property p_err_sticky;
      flash_error_flag |=> flash_error_flag;
   endproperty
   a_err_sticky: assert property (p_err_sticky)
      else $error("error flag dropped");
   property p_err_stop;
      flash_error_flag |=> !erase_mode && !program_mode;
   endproperty
   a_err_stop: assert property (p_err_stop)
      else $error("erase or program active under error");
   property p_rst_clear;
      !$past(rst_b) |-> {write_enable_gate, gated, flash_error_flag} == 8'h00;
   endproperty
   a_rst_clear: assert property (p_rst_clear)
      else $error("mode bits not cleared by reset");
endmodule // flash_program_erase_control_chk
bind flash_program_erase_control flash_program_erase_control_chk u_chk (
   .clk(clk), .rst_b(rst_b), .write_enable_gate(write_enable_gate),
   .erase_setup(erase_setup), .program_setup(program_setup),
   .erase_verify(erase_verify), .program_verify(program_verify),
   .erase_mode(erase_mode), .program_mode(program_mode),
   .erase_block_select(erase_block_select),
   .program_unit_addr(program_unit_addr),
   .flash_error_flag(flash_error_flag));
`default_nettype wire

// [test/flash_program_erase_control_tb.sv]
`timescale 1ns/100ps
`default_nettype none
module flash_program_erase_control_tb;
   logic clk, rst_b, awv, wv, bre, arv, rre, fail, busy;
   logic [7:0] awa, ara;
   logic [31:0] wd;
   wire awr, wrd, bv, arr, rv, g, es, ps, ev, pv, em, pm, ef, irq;
   wire [1:0] br, rr;
   wire [31:0] rdat;
   wire [4:0] sel;
   wire [14:0] unit;
   wire [6:0] mo = {g, es, ps, ev, pv, em, pm};
   int n_errors = 0, check_count = 0, cyc = 0, i;
   flash_program_erase_control u_flash_program_erase_control (
      .clk(clk), .rst_b(rst_b), .s_axi_awvalid(awv), .s_axi_awready(awr),
      .s_axi_awaddr(awa), .s_axi_wvalid(wv), .s_axi_wready(wrd),
      .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_bvalid(bv),
      .s_axi_bready(bre), .s_axi_bresp(br), .s_axi_arvalid(arv),
      .s_axi_arready(arr), .s_axi_araddr(ara), .s_axi_rvalid(rv),
      .s_axi_rready(rre), .s_axi_rdata(rdat), .s_axi_rresp(rr),
      .array_fail(fail), .array_busy(busy), .write_enable_gate(g),
      .erase_setup(es), .program_setup(ps), .erase_verify(ev),
      .program_verify(pv), .erase_mode(em), .program_mode(pm),
      .erase_block_select(sel), .program_unit_addr(unit),
      .flash_error_flag(ef), .irq(irq));
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task wrap_up;
      begin
         $display("checks %0d mismatches %0d", check_count, n_errors);
         if (n_errors == 0 && check_count > 0)
            $display("DONE - PASS");
         else
            $display("DONE - FAIL");
         $finish;
      end
   endtask
   // a hang ends the run well past the expected length
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 8000)
      begin
         n_errors++;
         wrap_up;
      end
   end
   task chk(input logic [31:0] got, input logic [31:0] exp);
      begin
         check_count++;
         if (got !== exp)
         begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
         end
      end
   endtask
   // the leading edge keeps two calls from driving in one time step
   task wr(input logic [7:0] a, input logic [7:0] d,
      input logic [1:0] er = 2'h0);
      begin
         @(posedge clk);
         awa <= a;
         wd <= {24'h000000, d};
         awv <= 1'b1;
         wv <= 1'b1;
         bre <= 1'b1;
         do
         begin
            @(posedge clk);
            awv <= awv & ~awr;
            wv <= wv & ~wrd;
         end
         while (!bv);
         bre <= 1'b0;
         chk({30'h0, br}, {30'h0, er});
      end
   endtask
   task rd(input logic [7:0] a, input logic [31:0] e,
      input logic [1:0] er = 2'h0);
      begin
         @(posedge clk);
         ara <= a;
         arv <= 1'b1;
         rre <= 1'b1;
         do
         begin
            @(posedge clk);
            arv <= arv & ~arr;
         end
         while (!rv);
         rre <= 1'b0;
         chk(rdat, e);
         chk({30'h0, rr}, {30'h0, er});
      end
   endtask
   task mode(input logic [7:0] d, input logic [6:0] e);
      begin
         wr(8'h00, d);
         rd(8'h00, {25'h0, e});
         chk({25'h0, mo}, {25'h0, e});
      end
   endtask
   initial
   begin
      rst_b = 1'b0;
      {awv, wv, bre, arv, rre, fail, busy} = 7'h00;
      {awa, ara, wd} = 48'h0;
      repeat (16) @(posedge clk);
      rst_b <= 1'b1;
      chk({24'h0, ef, mo}, 32'h0);
      wr(8'h00, 8'h40);
      rd(8'h00, 32'h0);
      chk({31'h0, g}, 32'h0);
      wr(8'h0C, 8'h80);
      rd(8'h0C, 32'h80);
      $display("test access done");
      mode(8'h3F, 7'h00);
      mode(8'h7F, 7'h40);
      mode(8'hFF, 7'h7C);
      mode(8'h40, 7'h40);
      mode(8'h62, 7'h60);
      mode(8'h62, 7'h62);
      mode(8'h51, 7'h50);
      mode(8'h51, 7'h51);
      mode(8'h4C, 7'h4C);
      $display("test mode done");
      // one block per erase, walked in turn
      for (i = 0; i < 5; i++)
      begin
         wr(8'h08, 8'h01 << i);
         rd(8'h08, 32'h1 << i);
         chk({27'h0, sel}, 32'h1 << i);
      end
      wr(8'h08, 8'h03);
      rd(8'h08, 32'h0);
      wr(8'h08, 8'h10);
      mode(8'h00, 7'h00);
      rd(8'h08, 32'h0);
      wr(8'h18, 8'hA5);
      rd(8'h18, 32'h5280);
      chk({17'h0, unit}, 32'h5280);
      wr(8'h1C, 8'h01, 2'h2);
      rd(8'h1C, 32'h0, 2'h2);
      $display("test select done");
      mode(8'h50, 7'h40);
      mode(8'h50, 7'h50);
      mode(8'h51, 7'h51);
      wr(8'h14, 8'h03);
      fail <= 1'b1;
      repeat (4) @(posedge clk);
      chk({31'h0, ef}, 32'h1);
      chk({31'h0, pm}, 32'h0);
      rd(8'h04, 32'h80);
      rd(8'h10, 32'h01);
      chk({31'h0, irq}, 32'h1);
      wr(8'h04, 8'h00);
      rd(8'h04, 32'h80);
      mode(8'h51, 7'h50);
      wr(8'h14, 8'h00);
      rd(8'h14, 32'h0);
      chk({31'h0, irq}, 32'h0);
      wr(8'h10, 8'h01);
      rd(8'h10, 32'h0);
      fail <= 1'b0;
      busy <= 1'b1;
      repeat (3) @(posedge clk);
      busy <= 1'b0;
      repeat (4) @(posedge clk);
      rd(8'h10, 32'h02);
      chk({31'h0, irq}, 32'h0);
      wr(8'h14, 8'h02);
      rd(8'h14, 32'h02);
      chk({31'h0, irq}, 32'h1);
      wr(8'h10, 8'h02);
      rd(8'h10, 32'h0);
      chk({31'h0, irq}, 32'h0);
      $display("test fault done");
      rst_b <= 1'b0;
      repeat (2) @(posedge clk);
      rst_b <= 1'b1;
      chk({24'h0, ef, mo}, 32'h0);
      $display("test reset done");
      wrap_up;
   end
endmodule // flash_program_erase_control_tb
`default_nettype wire
